// [verilog/psv_sequencer.sv]
// program counter, vectors, return stack and wake logic of the core
// How it works
// - ten-bit counter spans whole 1K program
// - reset starts fetching at address zero
// - software interrupt jumps to 0x001
// - every hardware interrupt jumps to 0x008
// - short call and jumps reach 256 words
// - medium jump reaches 512 words
// - long call and jump reach anywhere
// - calls and software interrupt push next address, hardware interrupt pushes current
// - all three returns pop into counter
// - branches and skips take two cycles
// - rolling code words are ordinary program
// - port bit zero interrupts when both enabled
// - low reset pin resets everything when selected
// - six hardware interrupt sources exist
// - any source wakes from standby
// - only watchdog, port, external wake halt
// - wake returns to running mode
`timescale 1ns/1ps
module psv_sequencer #(
    parameter int PC_W = psv_pkg::PC_W,
    parameter int STACK_DEPTH = psv_pkg::STACK_DEPTH
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // external reset pin
    input wire logic reset_pin_n,
    input wire logic reset_pin_select,
    // program memory fetch
    output logic [PC_W-1:0] pm_addr,
    output logic fetch_valid,
    // decoded instruction at pm_addr
    input wire logic [3:0] instr_op,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic skip_cond,
    // interrupt sources, pending levels
    input wire logic up_count_timer_evt,
    input wire logic down_count_timer_evt,
    input wire logic wdt_timeout_evt,
    input wire logic port_change_evt,
    input wire logic lvd_evt,
    input wire logic port_bit_zero,
    input wire logic ext_int_pin_select,
    input wire logic ext_int_enable,
    input wire logic int_global_enable,
    // status
    output logic int_taken,
    output logic standby_active,
    output logic halt_active
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

    initial
    begin
        if (PC_W <= psv_pkg::MEDIUM_W || (1 << PC_W) < psv_pkg::PM_WORDS)
            $error("psv_sequencer: PC_W cannot address program space");
        if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
            $error("psv_sequencer: STACK_DEPTH must be a power of two");
    end

    psv_pkg::psv_state_e state;
    psv_pkg::psv_state_e next_state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] stack_top;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] push_data;
    logic [psv_pkg::NUM_SRC-1:0] src;
    logic ext_req;
    logic pin_reset;
    logic int_accept;
    logic push;
    logic pop;

    function automatic logic [PC_W-1:0] short_target(input logic [PC_W-1:0] base,
                                                    input logic [PC_W-1:0] tgt);
        short_target = {base[PC_W-1:psv_pkg::SHORT_W], tgt[psv_pkg::SHORT_W-1:0]};
    endfunction

    assign pin_reset = reset_pin_select && !reset_pin_n;
    assign ext_req = port_bit_zero && ext_int_pin_select && ext_int_enable;
    assign src[psv_pkg::SRC_UP_TIMER] = up_count_timer_evt;
    assign src[psv_pkg::SRC_DOWN_TIMER] = down_count_timer_evt;
    assign src[psv_pkg::SRC_WDT] = wdt_timeout_evt;
    assign src[psv_pkg::SRC_PORT_CHANGE] = port_change_evt;
    assign src[psv_pkg::SRC_EXT] = ext_req;
    assign src[psv_pkg::SRC_LVD] = lvd_evt;

    assign pc_inc = pc + PC_W'(psv_pkg::PC_STEP);
    assign stack_top = stack_mem[sp - SP_ONE];
    assign int_accept = (state == psv_pkg::PSV_RUN) && int_global_enable && (|src);
    assign pm_addr = pc;
    assign fetch_valid = (state == psv_pkg::PSV_RUN);
    assign standby_active = (state == psv_pkg::PSV_STANDBY);
    assign halt_active = (state == psv_pkg::PSV_HALT);

    always_comb
    begin
        next_pc = pc;
        next_state = state;
        push = 1'b0;
        pop = 1'b0;
        push_data = pc_inc;
        case (state)
            psv_pkg::PSV_RUN:
            begin
                if (int_accept)
                begin
                    push = 1'b1;
                    push_data = pc;
                    next_pc = PC_W'(psv_pkg::HW_INT_VEC);
                    next_state = psv_pkg::PSV_FLUSH;
                end
                else
                begin
                    next_pc = pc_inc;
                    case (instr_op)
                        psv_pkg::OP_SKIP:
                        begin
                            if (skip_cond)
                                next_pc = pc + PC_W'(psv_pkg::PC_SKIP_STEP);
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_SHORT_CALL:
                        begin
                            push = 1'b1;
                            next_pc = short_target(pc, instr_target);
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_SHORT_ABS_JUMP:
                        begin
                            next_pc = short_target('0, instr_target);
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_SHORT_ABS_CALL:
                        begin
                            push = 1'b1;
                            next_pc = short_target('0, instr_target);
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_MEDIUM_JUMP:
                        begin
                            next_pc = {pc[PC_W-1:psv_pkg::MEDIUM_W],
                                       instr_target[psv_pkg::MEDIUM_W-1:0]};
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_LONG_CALL:
                        begin
                            push = 1'b1;
                            next_pc = instr_target;
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_LONG_JUMP:
                        begin
                            next_pc = instr_target;
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_SUBROUTINE_RETURN,
                        psv_pkg::OP_RETURN_WITH_LITERAL,
                        psv_pkg::OP_INTERRUPT_RETURN:
                        begin
                            pop = 1'b1;
                            next_pc = stack_top;
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_SOFT_INT:
                        begin
                            push = 1'b1;
                            next_pc = PC_W'(psv_pkg::SOFT_INT_VEC);
                            next_state = psv_pkg::PSV_FLUSH;
                        end
                        psv_pkg::OP_ENTER_STANDBY:
                            next_state = psv_pkg::PSV_STANDBY;
                        psv_pkg::OP_ENTER_HALT:
                            next_state = psv_pkg::PSV_HALT;
                        default:
                            next_state = psv_pkg::PSV_RUN;
                    endcase
                end
            end
            psv_pkg::PSV_FLUSH:
                next_state = psv_pkg::PSV_RUN;
            psv_pkg::PSV_STANDBY:
            begin
                if (|(src & psv_pkg::STANDBY_WAKE_MASK))
                    next_state = psv_pkg::PSV_RUN;
            end
            psv_pkg::PSV_HALT:
            begin
                if (|(src & psv_pkg::HALT_WAKE_MASK))
                    next_state = psv_pkg::PSV_RUN;
            end
            default:
                next_state = psv_pkg::PSV_RUN;
        endcase
    end

    // sequencing state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= psv_pkg::PSV_RUN;
            pc <= PC_W'(psv_pkg::RESET_VEC);
        end
        else if (pin_reset)
        begin
            state <= psv_pkg::PSV_RUN;
            pc <= PC_W'(psv_pkg::RESET_VEC);
        end
        else if (ce)
        begin
            state <= next_state;
            pc <= next_pc;
        end
    end

    // interrupt acceptance pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            int_taken <= 1'b0;
        else if (pin_reset)
            int_taken <= 1'b0;
        else if (ce)
            int_taken <= int_accept;
    end

    // return stack pointer, wraps when over-nested
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sp <= '0;
        else if (pin_reset)
            sp <= '0;
        else if (ce && push)
            sp <= sp + SP_ONE;
        else if (ce && pop)
            sp <= sp - SP_ONE;
    end

    // return stack storage
    always_ff @(posedge clk)
    begin
        if (ce && push && !pin_reset)
            stack_mem[sp] <= push_data;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n || pin_reset);

    sequence s_bubble;
        !fetch_valid ##1 (fetch_valid || !$past(ce));
    endsequence

    sequence s_run_exec(logic [3:0] op);
        ce && fetch_valid && !int_accept && instr_op == op;
    endsequence

    a_pin_reset_vec: assert property (disable iff (!arst_n)
        pin_reset |=> pm_addr == PC_W'(psv_pkg::RESET_VEC) && fetch_valid && sp == '0)
        else $error("reset pin did not restart at vector zero");
    a_hw_int_vec: assert property (
        ce && int_accept |=> pm_addr == PC_W'(psv_pkg::HW_INT_VEC) && int_taken
            && stack_top == $past(pc) ##0 s_bubble)
        else $error("hardware interrupt vector or push wrong");
    a_soft_int_vec: assert property (
        s_run_exec(psv_pkg::OP_SOFT_INT) |=> pm_addr == PC_W'(psv_pkg::SOFT_INT_VEC)
            && !int_taken)
        else $error("software interrupt vector wrong");
    a_short_reach: assert property (
        s_run_exec(psv_pkg::OP_SHORT_CALL) |=>
            pm_addr[PC_W-1:psv_pkg::SHORT_W] == $past(pc[PC_W-1:psv_pkg::SHORT_W])
            && pm_addr[psv_pkg::SHORT_W-1:0] == $past(instr_target[psv_pkg::SHORT_W-1:0]))
        else $error("short call left its 256-word span");
    a_medium_reach: assert property (
        s_run_exec(psv_pkg::OP_MEDIUM_JUMP) |=>
            pm_addr[PC_W-1:psv_pkg::MEDIUM_W] == $past(pc[PC_W-1:psv_pkg::MEDIUM_W])
            && pm_addr[psv_pkg::MEDIUM_W-1:0] == $past(instr_target[psv_pkg::MEDIUM_W-1:0]))
        else $error("medium jump left its 512-word span");
    a_long_reach: assert property (
        s_run_exec(psv_pkg::OP_LONG_JUMP) |=> pm_addr == $past(instr_target))
        else $error("long jump missed its target");
    a_call_push: assert property (
        s_run_exec(psv_pkg::OP_LONG_CALL) |=> stack_top == $past(pc_inc)
            && sp == $past(sp) + SP_ONE)
        else $error("call did not push the next address");
    a_return_pop: assert property (
        ce && fetch_valid && !int_accept && pop |=> pm_addr == $past(stack_top)
            && sp == $past(sp) - SP_ONE)
        else $error("return did not pop into the counter");
    a_branch_two_cycles: assert property (
        ce && fetch_valid && !int_accept && next_state == psv_pkg::PSV_FLUSH
            |=> s_bubble)
        else $error("branch or skip not two cycles");
    a_plain_one_cycle: assert property (
        s_run_exec(psv_pkg::OP_PLAIN) |=> fetch_valid
            && pm_addr == $past(pc) + PC_W'(psv_pkg::PC_STEP))
        else $error("plain instruction not one cycle");
    a_ext_int_gate: assert property (
        ce && fetch_valid && int_global_enable && !(ext_int_pin_select && ext_int_enable)
            && (src & ~(1 << psv_pkg::SRC_EXT)) == '0 |=> !int_taken)
        else $error("external interrupt taken while not selected");
    a_halt_filter: assert property (
        ce && halt_active && !wdt_timeout_evt && !port_change_evt && !ext_req
            |=> halt_active)
        else $error("halt left on a source that may not wake it");
    a_standby_wake: assert property (
        ce && standby_active && (|src) |=> fetch_valid && !standby_active)
        else $error("standby not left on a wake source");
    a_int_boundary: assert property (
        int_taken && $past(ce) |-> $past(fetch_valid) && !fetch_valid)
        else $error("interrupt taken off an instruction boundary");
endmodule

// [verilog/psv_pkg.sv]
// constants and types shared by the program sequencer
package psv_pkg;
    // program space
    localparam int PC_W = 10;
    localparam int PM_WORDS = 1024;
    localparam int INSTR_W = 14;
    localparam int STACK_DEPTH = 8;
    // reach of the short and medium forms, in target bits
    localparam int SHORT_W = 8;
    localparam int MEDIUM_W = 9;
    // fixed vectors
    localparam logic [9:0] RESET_VEC = 10'h000;
    localparam logic [9:0] SOFT_INT_VEC = 10'h001;
    localparam logic [9:0] HW_INT_VEC = 10'h008;
    // preset rolling code words, ordinary program space once released
    localparam logic [9:0] ROLL_LO = 10'h00E;
    localparam logic [9:0] ROLL_HI = 10'h00F;
    // reserved top words, no code may live there
    localparam logic [9:0] RESERVED_LO = 10'h3FE;
    localparam logic [9:0] PC_STEP = 10'h001;
    localparam logic [9:0] PC_SKIP_STEP = 10'h002;
    // decoded instruction classes
    localparam logic [3:0] OP_PLAIN = 4'h0;
    localparam logic [3:0] OP_SKIP = 4'h1;
    localparam logic [3:0] OP_SHORT_CALL = 4'h2;
    localparam logic [3:0] OP_SHORT_ABS_JUMP = 4'h3;
    localparam logic [3:0] OP_SHORT_ABS_CALL = 4'h4;
    localparam logic [3:0] OP_MEDIUM_JUMP = 4'h5;
    localparam logic [3:0] OP_LONG_CALL = 4'h6;
    localparam logic [3:0] OP_LONG_JUMP = 4'h7;
    localparam logic [3:0] OP_SUBROUTINE_RETURN = 4'h8;
    localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h9;
    localparam logic [3:0] OP_INTERRUPT_RETURN = 4'hA;
    localparam logic [3:0] OP_SOFT_INT = 4'hB;
    localparam logic [3:0] OP_ENTER_STANDBY = 4'hC;
    localparam logic [3:0] OP_ENTER_HALT = 4'hD;
    // hardware interrupt source positions
    localparam int NUM_SRC = 6;
    localparam int SRC_UP_TIMER = 0;
    localparam int SRC_DOWN_TIMER = 1;
    localparam int SRC_WDT = 2;
    localparam int SRC_PORT_CHANGE = 3;
    localparam int SRC_EXT = 4;
    localparam int SRC_LVD = 5;
    // sources able to leave halt: watchdog, port change, external
    localparam logic [5:0] HALT_WAKE_MASK = 6'h1C;
    localparam logic [5:0] STANDBY_WAKE_MASK = 6'h3F;

    typedef enum logic [1:0] {PSV_RUN, PSV_FLUSH, PSV_STANDBY, PSV_HALT} psv_state_e;
endpackage

// [verification/psv_prog_mem.sv]
// program memory model handing decoded words to the sequencer
`timescale 1ns/1ps
module psv_prog_mem (
    // fetch side
    input wire logic [9:0] pm_addr,
    input wire logic fetch_valid,
    // decoded word at pm_addr
    output logic [3:0] instr_op,
    output logic [9:0] instr_target,
    output logic skip_cond
);
    logic [14:0] word [0:1023];

    initial
    begin
        for (int i = 0; i < 1024; i++)
            word[i] = {psv_pkg::OP_PLAIN, 11'h000};
    end

    // words not fetched show inverted contents, never a stale copy
    assign {instr_op, instr_target, skip_cond} = fetch_valid ? word[pm_addr] : ~word[pm_addr];

    task automatic load(input logic [9:0] a, input logic [3:0] op, input logic [9:0] t,
                        input logic s);
        begin
            // top two words stay empty; rolling code words load like any other
            if (a < psv_pkg::RESERVED_LO)
                word[a] = {op, t, s};
        end
    endtask
endmodule

// [verification/psv_sequencer_tb.sv]
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module psv_sequencer_tb;
    logic clk;
    logic arst_n;
    logic ce;
    logic reset_pin_n;
    logic reset_pin_select;
    logic [9:0] pm_addr;
    logic fetch_valid;
    logic [3:0] instr_op;
    logic [9:0] instr_target;
    logic skip_cond;
    logic [5:0] src;
    logic ext_sel;
    logic ext_en;
    logic gie;
    logic int_taken;
    logic standby_active;
    logic halt_active;
    logic [9:0] pc;
    logic [9:0] stk [$];
    logic [15:0] rnd;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    psv_sequencer DUT (
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .reset_pin_n(reset_pin_n), .reset_pin_select(reset_pin_select),
        .pm_addr(pm_addr), .fetch_valid(fetch_valid),
        .instr_op(instr_op), .instr_target(instr_target), .skip_cond(skip_cond),
        .up_count_timer_evt(src[psv_pkg::SRC_UP_TIMER]),
        .down_count_timer_evt(src[psv_pkg::SRC_DOWN_TIMER]),
        .wdt_timeout_evt(src[psv_pkg::SRC_WDT]),
        .port_change_evt(src[psv_pkg::SRC_PORT_CHANGE]),
        .lvd_evt(src[psv_pkg::SRC_LVD]), .port_bit_zero(src[psv_pkg::SRC_EXT]),
        .ext_int_pin_select(ext_sel), .ext_int_enable(ext_en), .int_global_enable(gie),
        .int_taken(int_taken), .standby_active(standby_active), .halt_active(halt_active)
    );

    psv_prog_mem PM (
        .pm_addr(pm_addr), .fetch_valid(fetch_valid),
        .instr_op(instr_op), .instr_target(instr_target), .skip_cond(skip_cond)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [9:0] next_pc(input logic [3:0] op, input logic [9:0] a,
                                           input logic [9:0] t, input logic s);
        case (op)
            psv_pkg::OP_SKIP: return a + (s ? 10'h002 : 10'h001);
            psv_pkg::OP_SHORT_CALL: return {a[9:8], t[7:0]};
            psv_pkg::OP_SHORT_ABS_JUMP, psv_pkg::OP_SHORT_ABS_CALL: return {2'b00, t[7:0]};
            psv_pkg::OP_MEDIUM_JUMP: return {a[9], t[8:0]};
            psv_pkg::OP_LONG_CALL, psv_pkg::OP_LONG_JUMP: return t;
            psv_pkg::OP_SOFT_INT: return psv_pkg::SOFT_INT_VEC;
            default: return a + 10'h001;
        endcase
    endfunction

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                err_total++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task automatic report_and_stop;
        begin
            $display("checks=%0d mismatches=%0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // one instruction at pc, with its bubble where it has one
    task automatic exec(input logic [3:0] op, input logic [9:0] t, input logic s);
        logic [9:0] nx;
        logic run;
        begin
            nx = next_pc(op, pc, t, s);
            run = (op == psv_pkg::OP_PLAIN);
            if (op inside {psv_pkg::OP_SHORT_CALL, psv_pkg::OP_SHORT_ABS_CALL,
                           psv_pkg::OP_LONG_CALL, psv_pkg::OP_SOFT_INT})
                stk.push_back(pc + 10'h001);
            if (op inside {psv_pkg::OP_SUBROUTINE_RETURN, psv_pkg::OP_RETURN_WITH_LITERAL,
                           psv_pkg::OP_INTERRUPT_RETURN})
                nx = stk.pop_back();
            PM.load(pc, op, t, s);
            @(posedge clk);
            #1;
            chk(pm_addr, nx);
            chk(10'(fetch_valid), 10'(run));
            if (!run)
            begin
                @(posedge clk);
                #1;
                chk(10'(fetch_valid), 10'h001);
            end
            pc = nx;
        end
    endtask

    // raise source k under cfg {gie, pin select, enable}
    task automatic irq(input int k, input logic [2:0] cfg, input logic take);
        begin
            PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
            @(posedge clk);
            src <= 6'h01 << k;
            {gie, ext_sel, ext_en} <= cfg;
            #1;
            pc = pc + 10'h001;
            PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
            @(posedge clk);
            #1;
            chk(10'(int_taken), 10'(take));
            if (take)
                stk.push_back(pc);
            pc = take ? psv_pkg::HW_INT_VEC : pc + 10'h001;
            chk(pm_addr, pc);
            PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
            @(posedge clk);
            src <= 6'h00;
            #1;
            if (!take)
                pc = pc + 10'h001;
        end
    endtask

    // sleep, ignore quiet sources, then wake on source k
    task automatic nap(input logic [3:0] op, input logic [5:0] quiet, input int k);
        begin
            PM.load(pc, op, 10'h000, 1'b0);
            @(posedge clk);
            src <= quiet;
            #1;
            pc = pc + 10'h001;
            PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
            chk(10'({standby_active, halt_active}),
                (op == psv_pkg::OP_ENTER_HALT) ? 10'h001 : 10'h002);
            repeat (3) @(posedge clk);
            #1;
            chk(10'(fetch_valid), 10'h000);
            chk(pm_addr, pc);
            @(posedge clk);
            src <= 6'h01 << k;
            @(posedge clk);
            src <= 6'h00;
            #1;
            chk(10'(fetch_valid), 10'h001);
            chk(10'({standby_active, halt_active}), 10'h000);
        end
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        reset_pin_n = 1'b1;
        reset_pin_select = 1'b0;
        src = 6'h00;
        {gie, ext_sel, ext_en} = 3'h0;
        pc = 10'h000;
        rnd = 16'h0040;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(pm_addr, psv_pkg::RESET_VEC);
        chk(10'(fetch_valid), 10'h001);
        exec(psv_pkg::OP_LONG_JUMP, 10'h00C, 1'b0);
        repeat (4) exec(psv_pkg::OP_PLAIN, 10'h000, 1'b0);
        exec(psv_pkg::OP_LONG_JUMP, 10'h3FD, 1'b0);
        exec(psv_pkg::OP_LONG_JUMP, 10'h000, 1'b0);
        for (int i = 0; i < 45; i++)
        begin
            rnd = lfsr(rnd);
            exec((i % 9 == 8) ? psv_pkg::OP_SOFT_INT : 4'(i % 9),
                 rnd[9:0] & 10'h3BF, rnd[15]);
            if (stk.size() > 0)
                exec(4'(psv_pkg::OP_SUBROUTINE_RETURN + i % 3), 10'h000, 1'b0);
        end
        // frozen while the enable is low; the edge that lowers it still runs a plain word
        PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        #1;
        pc = pc + 10'h001;
        PM.load(pc, psv_pkg::OP_LONG_JUMP, 10'h155, 1'b0);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk(pm_addr, pc);
        exec(psv_pkg::OP_LONG_JUMP, 10'h155, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            exec(psv_pkg::OP_LONG_CALL, rnd[9:0] & 10'h3BF, 1'b0);
        end
        for (int i = 0; i < 8; i++)
            exec(4'(psv_pkg::OP_SUBROUTINE_RETURN + i % 3), 10'h000, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            irq(k, 3'b111, 1'b1);
            exec(psv_pkg::OP_INTERRUPT_RETURN, 10'h000, 1'b0);
        end
        irq(psv_pkg::SRC_EXT, 3'b101, 1'b0);
        irq(psv_pkg::SRC_EXT, 3'b110, 1'b0);
        irq(psv_pkg::SRC_UP_TIMER, 3'b011, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            nap(psv_pkg::OP_ENTER_STANDBY, 6'h00, k);
            nap(psv_pkg::OP_ENTER_HALT, ~psv_pkg::HALT_WAKE_MASK,
                psv_pkg::HALT_WAKE_MASK[k] ? k : psv_pkg::SRC_WDT);
        end
        // pin low is ignored until its function is selected
        PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        #1;
        pc = pc + 10'h001;
        PM.load(pc, psv_pkg::OP_PLAIN, 10'h000, 1'b0);
        @(posedge clk);
        reset_pin_select <= 1'b1;
        #1;
        chk(pm_addr, pc + 10'h001);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        #1;
        chk(pm_addr, psv_pkg::RESET_VEC);
        pc = 10'h000;
        stk.delete();
        exec(psv_pkg::OP_PLAIN, 10'h000, 1'b0);
        report_and_stop();
    end
endmodule
